// *** adc_frame_integrity_defines.svh ***
// Register offsets, field positions, reset values and code constants
// Assumes inclusion by the frame integrity core only
`ifndef ADC_FRAME_INTEGRITY_DEFINES_SVH
`define ADC_FRAME_INTEGRITY_DEFINES_SVH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_CHAN_EN 8'h04
`define REG_STATUS 8'h08
`define REG_ERR_COUNT 8'h0c
`define REG_STATUS_WORD 8'h10
`define REG_LAST_CMD 8'h14

// Control fields
`define CTRL_CRC_EN_BIT 0
`define CTRL_CRC_MODE_BIT 1
`define CTRL_FIXED_BIT 2
`define CTRL_RESET 3'h0
`define CHAN_EN_RESET 4'h0
`define STATUS_WORD_RESET 16'h0000

// Status fields
`define STAT_CHECK_FAULT_BIT 0
`define STAT_WL_LSB 2
`define STAT_HAM_BIT 4
`define STAT_CFG_BAD_BIT 5

// Code constants
`define CLIP16_POS 16'h7fff
`define CLIP16_NEG 16'h8000
`define CLIP24_POS 24'h7fffff
`define CLIP24_NEG 24'h800000
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hffff
`define MULTI_WRITE_MASK 16'he000
`define MULTI_WRITE_VALUE 16'h6000

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** adc_frame_integrity_pkg.sv ***
// Types shared by the frame integrity core and its bench
// Assumes an AXI4-Lite master with 8-bit byte addresses
package adc_frame_integrity_pkg;
  typedef enum logic [1:0] {WL16, WL24, WL32} word_len_e;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } spi_in_s;

  typedef struct packed {
    logic dout;
    logic dout_oe_n;
  } spi_out_s;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic crc_err;
    logic multi_write;
  } cmd_s;

  typedef struct packed {
    logic valid;
    logic [23:0] data;
    logic corrected;
    logic multi_err;
  } in_word_s;
endpackage : adc_frame_integrity_pkg

// *** adc_frame_integrity.sv ***
// Frame formatting, Hamming and CRC checking for the serial data port
// Assumes SPI mode CPOL 0 / CPHA 1, host-driven clock well below core_clk_i
module adc_frame_integrity
  import adc_frame_integrity_pkg::*;
#(
  parameter int NCH = 4,
  parameter int SRC_W = 26
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Straps: bit 1 floating, bit 0 level
  input wire logic [1:0] word_length_strap_i,
  input wire logic [1:0] hamming_enable_strap_i,
  // Conversion results
  input wire logic conv_load_i,
  input wire logic [NCH*SRC_W-1:0] conv_data_i,
  // Serial link
  input wire spi_in_s spi_i,
  output spi_out_s spi_o,
  // Decoded input words and commands
  output in_word_s in_word_o,
  output cmd_s cmd_o,
  // Register bus
  input wire axil_req_s axil_i,
  output axil_rsp_s axil_o
);
`include "adc_frame_integrity_defines.svh"

  initial begin
    if (!(NCH == 2 || NCH == 4) || SRC_W <= 24) begin
      $error("adc_frame_integrity: NCH must be 2 or 4 and SRC_W above 24");
    end
  end

  typedef struct packed {
    logic cs_s1, cs_s2, sck_s1, sck_s2, sck_d, din_s1, din_s2;
    logic [1:0] wls1, wls2, hms1, hms2;
    logic strap_done;
    logic [1:0] strap_wait;
    word_len_e wl;
    logic ham_en, cfg_bad;
    logic crc_en, crc_mode, fixed;
    logic [NCH-1:0] chan_en;
    logic [15:0] stat_word;
    logic [NCH-1:0][23:0] chan_data;
    logic check_fault;
    logic [7:0] err_cnt;
    logic [15:0] last_cmd, cmd_word, last_word;
    logic in_frame;
    logic [5:0] bit_cnt, idx;
    logic [31:0] in_sh, out_sh;
    logic dout;
    logic [15:0] crc_in, crc_prev, crc_out;
    cmd_s cmd;
    in_word_s iw;
    logic aw_got, w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } state_s;

  state_s st_reg, st_next;

  function automatic logic [23:0] clip_code(input logic signed [SRC_W-1:0] raw);
    logic signed [SRC_W-1:0] hi, lo;
    hi = {{(SRC_W-24){1'b0}}, `CLIP24_POS};
    lo = {{(SRC_W-24){1'b1}}, `CLIP24_NEG};
    if (raw > hi) begin
      return `CLIP24_POS;
    end else if (raw < lo) begin
      return `CLIP24_NEG;
    end
    return raw[23:0];
  endfunction : clip_code

  // Syndrome contribution of data bits over code positions 1..29
  function automatic logic [4:0] ham_gen(input logic [23:0] d);
    logic [4:0] s;
    int di;
    s = '0;
    di = 0;
    for (int p = 1; p < 30; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[di]) begin
          s = s ^ 5'(p);
        end
        di++;
      end
    end
    return s;
  endfunction : ham_gen

  function automatic logic [23:0] ham_fix(input logic [23:0] d, input logic [4:0] syn);
    logic [23:0] r;
    int di;
    r = d;
    di = 0;
    for (int p = 1; p < 30; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (5'(p) == syn) begin
          r[di] = ~r[di];
        end
        di++;
      end
    end
    return r;
  endfunction : ham_fix

  function automatic logic [7:0] ham_byte(input logic [23:0] f);
    logic [4:0] h;
    h = ham_gen(f);
    return {h, ^f, ^h, 1'b0};
  endfunction : ham_byte

  function automatic logic [31:0] pack_word(input logic [23:0] f, input logic ham,
                                            input word_len_e wl);
    logic [31:0] w;
    case (wl)
      WL32: w = ham ? {f, ham_byte(f)} : {f, 8'h00};
      WL24: w = ham ? {f[23:8], ham_byte(f), 8'h00} : {f, 8'h00};
      default: w = {f[23:8], 16'h0000};
    endcase
    return w;
  endfunction : pack_word

  function automatic logic [15:0] crc_byte(input logic [15:0] c_in, input logic [7:0] b);
    logic [15:0] c;
    c = c_in ^ {b, 8'h00};
    for (int k = 0; k < 8; k++) begin
      c = c[15] ? ({c[14:0], 1'b0} ^ `CRC_POLY) : {c[14:0], 1'b0};
    end
    return c;
  endfunction : crc_byte

  function automatic logic [15:0] crc_word(input logic [15:0] c_in, input logic [31:0] w,
                                           input logic [2:0] n);
    logic [15:0] c;
    c = c_in;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(n)) begin
        c = crc_byte(c, w[31-8*i -: 8]);
      end
    end
    return c;
  endfunction : crc_word

  function automatic logic [5:0] wl_bits(input word_len_e wl);
    return (wl == WL32) ? 6'd32 : (wl == WL24) ? 6'd24 : 6'd16;
  endfunction : wl_bits

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : strb_merge

  // Conversion field, CRC byte count and frame shape
  logic fmt16, word_end, frame_end, frame_start, sck_rise, sck_fall, bad_crc;
  logic rd_errcnt;
  logic [2:0] crc_nbytes;
  logic [5:0] nwords, n_en;
  logic [31:0] in_al, out_word;
  logic [23:0] in_field, fixed_field, out_field;
  logic [7:0] in_hb;
  logic [4:0] syn;
  logic overall;
  logic [31:0] wmerge;

  always_comb begin
    n_en = '0;
    for (int c = 0; c < NCH; c++) begin
      n_en = n_en + 6'(st_reg.chan_en[c]);
    end
  end

  assign fmt16 = (st_reg.wl == WL16) || (st_reg.wl == WL24 && st_reg.ham_en);
  assign crc_nbytes = st_reg.ham_en ? 3'((wl_bits(st_reg.wl) - 6'd8) >> 3)
                                    : 3'(wl_bits(st_reg.wl) >> 3);
  assign nwords = st_reg.fixed ? 6'(NCH + 2) : 6'd1 + n_en + 6'(st_reg.crc_en);
  assign sck_rise = st_reg.sck_s2 && !st_reg.sck_d;
  assign sck_fall = !st_reg.sck_s2 && st_reg.sck_d;
  assign frame_start = !st_reg.in_frame && !st_reg.cs_s2;
  assign frame_end = st_reg.in_frame && st_reg.cs_s2;
  assign word_end = st_reg.in_frame && !st_reg.cs_s2 && sck_fall
                    && (st_reg.bit_cnt == wl_bits(st_reg.wl) - 6'd1);
  assign bad_crc = st_reg.crc_en && st_reg.idx >= 6'd2 && st_reg.crc_prev != st_reg.last_word;
  assign rd_errcnt = axil_i.arvalid && !st_reg.rvalid && axil_i.araddr == `REG_ERR_COUNT;

  // Received word, left aligned, then split into field and Hamming byte
  always_comb begin
    in_al = {st_reg.in_sh[30:0], st_reg.din_s2} << (6'd32 - wl_bits(st_reg.wl));
    if (st_reg.ham_en && st_reg.wl == WL24) begin
      in_field = {in_al[31:16], 8'h00};
      in_hb = in_al[15:8];
    end else if (st_reg.ham_en) begin
      in_field = in_al[31:8];
      in_hb = in_al[7:0];
    end else begin
      in_field = in_al[31:8];
      in_hb = 8'h00;
    end
    syn = ham_gen(in_field) ^ in_hb[7:3];
    overall = ^{in_field, in_hb[7:1]};
    fixed_field = (st_reg.ham_en && overall) ? ham_fix(in_field, syn) : in_field;
  end

  // Outgoing word by index: status, data, CRC, then zero padding
  always_comb begin
    int k;
    k = 0;
    out_field = '0;
    if (st_reg.idx == 6'd0) begin
      // status in 16 MSBs, zero padded
      out_field = {st_reg.stat_word, 8'h00};
    end else if (st_reg.crc_en && st_reg.idx == nwords - 6'd1) begin
      // CRC in MSBs of last word
      out_field = {st_reg.crc_out, 8'h00};
    end else if (st_reg.fixed && st_reg.idx <= 6'(NCH)) begin
      out_field = st_reg.chan_data[int'(st_reg.idx) - 1];
    end else if (!st_reg.fixed && st_reg.idx <= n_en) begin
      for (int c = 0; c < NCH; c++) begin
        if (st_reg.chan_en[c]) begin
          k++;
          if (k == int'(st_reg.idx)) begin
            out_field = st_reg.chan_data[c];
          end
        end
      end
    end
    if (fmt16) begin
      out_field[7:0] = 8'h00;
    end
    out_word = (st_reg.idx < nwords) ? pack_word(out_field, st_reg.ham_en, st_reg.wl) : '0;
  end

  always_comb begin
    st_next = st_reg;
    wmerge = '0;
    st_next.cmd.valid = 1'b0;
    st_next.iw.valid = 1'b0;
    st_next.cs_s1 = spi_i.cs_n;
    st_next.cs_s2 = st_reg.cs_s1;
    st_next.sck_s1 = spi_i.sclk;
    st_next.sck_s2 = st_reg.sck_s1;
    st_next.sck_d = st_reg.sck_s2;
    st_next.din_s1 = spi_i.din;
    st_next.din_s2 = st_reg.din_s1;
    st_next.wls1 = word_length_strap_i;
    st_next.wls2 = st_reg.wls1;
    st_next.hms1 = hamming_enable_strap_i;
    st_next.hms2 = st_reg.hms1;

    // strap caught once, later changes ignored
    // Synchronisers hold reset values for two edges after release
    if (!st_reg.strap_done && st_reg.strap_wait != 2'd2) begin
      st_next.strap_wait = st_reg.strap_wait + 2'd1;
    end else if (!st_reg.strap_done) begin
      st_next.strap_done = 1'b1;
      st_next.wl = st_reg.wls2[1] ? WL16 : (st_reg.wls2[0] ? WL32 : WL24);
      // Hamming refused for 16-bit or floating strap
      st_next.cfg_bad = st_reg.hms2[1] || (st_reg.hms2[0] && st_reg.wls2[1]);
      st_next.ham_en = !st_reg.hms2[1] && st_reg.hms2[0] && !st_reg.wls2[1];
    end

    if (conv_load_i) begin
      for (int c = 0; c < NCH; c++) begin
        st_next.chan_data[c] = clip_code(conv_data_i[c*SRC_W +: SRC_W]);
      end
    end

    if (frame_start) begin
      st_next.in_frame = 1'b1;
      st_next.bit_cnt = '0;
      st_next.idx = '0;
      st_next.crc_in = `CRC_INIT;
      st_next.crc_prev = `CRC_INIT;
      st_next.crc_out = `CRC_INIT;
      st_next.dout = 1'b0;
    end else if (frame_end) begin
      st_next.in_frame = 1'b0;
      if (bad_crc) begin
        st_next.check_fault = 1'b1;
        st_next.err_cnt = st_reg.err_cnt + 8'd1;
      end
      st_next.cmd.word = st_reg.cmd_word;
      st_next.cmd.crc_err = bad_crc;
      st_next.cmd.multi_write = (st_reg.cmd_word & `MULTI_WRITE_MASK) == `MULTI_WRITE_VALUE;
      // drop on bad CRC unless multi-register write
      st_next.cmd.valid = st_reg.idx != 6'd0 && (!bad_crc || st_next.cmd.multi_write);
      if (st_next.cmd.valid) begin
        st_next.last_cmd = st_reg.cmd_word;
      end
    end else if (st_reg.in_frame) begin
      if (sck_rise && st_reg.bit_cnt == 6'd0) begin
        st_next.dout = out_word[31];
        st_next.out_sh = {out_word[30:0], 1'b0};
        if (st_reg.idx < nwords && !(st_reg.crc_en && st_reg.idx == nwords - 6'd1)) begin
          // output CRC over the words before the CRC word, not the CRC word or zero padding
          st_next.crc_out = crc_word(st_reg.crc_out, out_word, crc_nbytes);
        end
      end else if (sck_rise) begin
        st_next.dout = st_reg.out_sh[31];
        st_next.out_sh = {st_reg.out_sh[30:0], 1'b0};
      end
      if (sck_fall) begin
        st_next.in_sh = {st_reg.in_sh[30:0], st_reg.din_s2};
        st_next.bit_cnt = st_reg.bit_cnt + 6'd1;
      end
      if (word_end) begin
        st_next.bit_cnt = '0;
        st_next.idx = st_reg.idx + 6'd1;
        st_next.iw.valid = 1'b1;
        st_next.iw.data = fixed_field;
        st_next.iw.corrected = st_reg.ham_en && overall && syn != 5'd0;
        st_next.iw.multi_err = st_reg.ham_en && !overall && syn != 5'd0;
        if (st_reg.idx == 6'd0) begin
          st_next.cmd_word = fixed_field[23:8];
        end
        st_next.last_word = fixed_field[23:8];
        st_next.crc_prev = st_reg.crc_in;
        // mode 0 skips zero filler words
        if (st_reg.crc_mode || st_reg.idx == 6'd0 || fixed_field != 24'h0) begin
          st_next.crc_in = crc_word(st_reg.crc_in, {fixed_field, 8'h00}, crc_nbytes);
        end
      end
    end

    // Register bus: write address and data in either order
    if (axil_i.awvalid && !st_reg.aw_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = axil_i.awaddr;
    end
    if (axil_i.wvalid && !st_reg.w_got && !st_reg.bvalid) begin
      st_next.w_got = 1'b1;
      st_next.wdata = axil_i.wdata;
      st_next.wstrb = axil_i.wstrb;
    end
    if (st_reg.aw_got && st_reg.w_got) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = `RESP_OKAY;
      if (st_reg.awaddr == `REG_CTRL) begin
        wmerge = strb_merge({29'h0, st_reg.fixed, st_reg.crc_mode, st_reg.crc_en},
                            st_reg.wdata, st_reg.wstrb);
        {st_next.fixed, st_next.crc_mode, st_next.crc_en} = wmerge[2:0];
      end else if (st_reg.awaddr == `REG_CHAN_EN) begin
        wmerge = strb_merge(32'(st_reg.chan_en), st_reg.wdata, st_reg.wstrb);
        st_next.chan_en = wmerge[NCH-1:0];
      end else if (st_reg.awaddr == `REG_STATUS) begin
        // Write one clears; a frame error in the same cycle wins
        if (st_reg.wstrb[0] && st_reg.wdata[`STAT_CHECK_FAULT_BIT] && !(frame_end && bad_crc)) begin
          st_next.check_fault = 1'b0;
        end
      end else if (st_reg.awaddr == `REG_STATUS_WORD) begin
        wmerge = strb_merge(32'(st_reg.stat_word), st_reg.wdata, st_reg.wstrb);
        st_next.stat_word = wmerge[15:0];
      end else if (st_reg.awaddr != `REG_ERR_COUNT && st_reg.awaddr != `REG_LAST_CMD) begin
        st_next.bresp = `RESP_SLVERR;
      end
    end else if (st_reg.bvalid && axil_i.bready) begin
      st_next.bvalid = 1'b0;
    end

    if (axil_i.arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = `RESP_OKAY;
      st_next.rdata = '0;
      if (axil_i.araddr == `REG_CTRL) begin
        st_next.rdata = {29'h0, st_reg.fixed, st_reg.crc_mode, st_reg.crc_en};
      end else if (axil_i.araddr == `REG_CHAN_EN) begin
        st_next.rdata = 32'(st_reg.chan_en);
      end else if (axil_i.araddr == `REG_STATUS) begin
        st_next.rdata[`STAT_CHECK_FAULT_BIT] = st_reg.check_fault;
        st_next.rdata[`STAT_WL_LSB +: 2] = st_reg.wl;
        st_next.rdata[`STAT_HAM_BIT] = st_reg.ham_en;
        st_next.rdata[`STAT_CFG_BAD_BIT] = st_reg.cfg_bad;
      end else if (axil_i.araddr == `REG_ERR_COUNT) begin
        st_next.rdata = 32'(st_reg.err_cnt);
        // read clears; a same-cycle error still counts
        st_next.err_cnt = (frame_end && bad_crc) ? 8'd1 : 8'd0;
      end else if (axil_i.araddr == `REG_STATUS_WORD) begin
        st_next.rdata = 32'(st_reg.stat_word);
      end else if (axil_i.araddr == `REG_LAST_CMD) begin
        st_next.rdata = 32'(st_reg.last_cmd);
      end else begin
        st_next.rresp = `RESP_SLVERR;
      end
    end else if (st_reg.rvalid && axil_i.rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
      st_reg.cs_s1 <= 1'b1;
      st_reg.cs_s2 <= 1'b1;
      {st_reg.fixed, st_reg.crc_mode, st_reg.crc_en} <= `CTRL_RESET;
      st_reg.chan_en <= `CHAN_EN_RESET;
      st_reg.stat_word <= `STATUS_WORD_RESET;
      st_reg.wl <= WL16;
    end else begin
      st_reg <= st_next;
    end
  end

  assign spi_o.dout = st_reg.dout;
  assign spi_o.dout_oe_n = !(st_reg.in_frame && !st_reg.cs_s2);
  assign in_word_o = st_reg.iw;
  assign cmd_o = st_reg.cmd;
  assign axil_o.awready = !st_reg.aw_got && !st_reg.bvalid;
  assign axil_o.wready = !st_reg.w_got && !st_reg.bvalid;
  assign axil_o.bvalid = st_reg.bvalid;
  assign axil_o.bresp = st_reg.bresp;
  assign axil_o.arready = !st_reg.rvalid;
  assign axil_o.rvalid = st_reg.rvalid;
  assign axil_o.rdata = st_reg.rdata;
  assign axil_o.rresp = st_reg.rresp;

  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence bad_close_s;
    frame_end && bad_crc && !rd_errcnt;
  endsequence
  sequence fault_seen_s;
    st_reg.check_fault ##1 st_reg.check_fault;
  endsequence

  clip_positive_a: assert property (
    conv_load_i && $signed(conv_data_i[SRC_W-1:0]) > $signed({{(SRC_W-24){1'b0}}, `CLIP24_POS})
    |=> st_reg.chan_data[0] == `CLIP24_POS && (!fmt16 || st_reg.chan_data[0][23:8] == `CLIP16_POS))
    else $error("positive clip code wrong");
  clip_negative_a: assert property (
    conv_load_i && $signed(conv_data_i[SRC_W-1:0]) < $signed({{(SRC_W-24){1'b1}}, `CLIP24_NEG})
    |=> st_reg.chan_data[0] == `CLIP24_NEG)
    else $error("negative clip code wrong");
  ham_byte_zero_a: assert property (
    sck_rise && st_reg.in_frame && !st_reg.cs_s2 && st_reg.bit_cnt == 6'd0 && st_reg.ham_en
    && st_reg.wl == WL32 |-> out_word[0] == 1'b0 && out_word[7:3] == ham_gen(out_word[31:8]))
    else $error("Hamming byte malformed");
  pad_zero_a: assert property (
    st_reg.wl == WL32 && !st_reg.ham_en |-> out_word[7:0] == 8'h00)
    else $error("unused low byte not zero");
  fault_on_crc_a: assert property (
    bad_close_s |=> fault_seen_s)
    else $error("check fault not raised");
  count_step_a: assert property (
    bad_close_s |=> st_reg.err_cnt == $past(st_reg.err_cnt) + 8'd1)
    else $error("error count not advanced");
  drop_command_a: assert property (
    frame_end && bad_crc && (st_reg.cmd_word & `MULTI_WRITE_MASK) != `MULTI_WRITE_VALUE
    |=> !cmd_o.valid ##1 !cmd_o.valid)
    else $error("command executed despite CRC error");
  crc_preset_a: assert property (
    frame_start |=> st_reg.crc_in == `CRC_INIT && st_reg.crc_out == `CRC_INIT)
    else $error("CRC not preset");
  strap_hold_a: assert property (
    st_reg.strap_done |=> $stable(st_reg.wl) && $stable(st_reg.ham_en))
    else $error("strap value changed after capture");
endmodule : adc_frame_integrity

// *** host_spi_model.sv ***
// SPI host model: frames of 24-bit words, CPOL 0 / CPHA 1
// Assumes the bench fills tx before xfer and reads rx after it
module host_spi_model (
  // Serial link
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o,
  input wire logic dout_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] tx [6];
  logic [23:0] rx [6];
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  // Clock runs only inside frames; dout taken late for sync margin
  task automatic xfer(input int nw);
    #3 cs_n_o = 1'b0;
    #80;
    for (int w = 0; w < nw; w++) begin
      for (int b = 23; b >= 0; b--) begin
        sclk_o = 1'b1;
        din_o = tx[w][b];
        #40 sclk_o = 1'b0;
        #39 rx[w][b] = dout_i;
        #1;
      end
    end
    #80 cs_n_o = 1'b1;
    din_o = ~din_o;
    #300;
  endtask : xfer
endmodule : host_spi_model

// *** adc_frame_integrity_tb_top.sv ***
// Bench: register bus tasks plus framed serial traffic
// Assumes 24-bit word strap, Hamming off, four channels
module adc_frame_integrity_tb_top import adc_frame_integrity_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i, nrst_i, load, cs_n, sclk, din;
  logic [1:0] wl, ham;
  logic [103:0] conv;
  axil_req_s rq;
  axil_rsp_s rs;
  spi_in_s si;
  spi_out_s so;
  int errors, compares;
  logic [23:0] ex [6];
  assign si = '{cs_n: cs_n, sclk: sclk, din: din};
  adc_frame_integrity #(.NCH(4), .SRC_W(26)) i_adc_frame_integrity (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .word_length_strap_i(wl),
    .hamming_enable_strap_i(ham), .conv_load_i(load), .conv_data_i(conv),
    .spi_i(si), .spi_o(so), .in_word_o(), .cmd_o(), .axil_i(rq), .axil_o(rs));
  host_spi_model i_host_spi_model (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .dout_i(so.dout));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic test_done();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      errors++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge core_clk_i);
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= d;
    rq.wstrb <= 4'hf;
    rq.bready <= 1'b1;
    while (!done) begin
      @(posedge core_clk_i);
      if (rq.awvalid && rs.awready === 1'b1) rq.awvalid <= 1'b0;
      if (rq.wvalid && rs.wready === 1'b1) rq.wvalid <= 1'b0;
      if (rs.bvalid === 1'b1) begin
        rq.bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge core_clk_i);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    while (!done) begin
      @(posedge core_clk_i);
      if (rq.arvalid && rs.arready === 1'b1) rq.arvalid <= 1'b0;
      if (rs.rvalid === 1'b1) begin
        rq.rready <= 1'b0;
        done = 1'b1;
        chk(rs.rdata, e);
        chk({30'h0, rs.rresp}, {30'h0, er});
      end
    end
  endtask : rd
  // Bytewise CRC over words, optionally skipping zero filler
  function automatic logic [15:0] crc(input int nw, input logic [23:0] w [6], input logic zs);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < nw; i++) begin
      if (!(zs && w[i] == 24'h0)) begin
        for (int k = 2; k >= 0; k--) begin
          c = c ^ {w[i][k*8 +: 8], 8'h00};
          for (int j = 0; j < 8; j++) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
        end
      end
    end
    return c;
  endfunction : crc
  // One frame: command, zero filler, CRC last (flip corrupts it)
  task automatic fr(input int nw, input logic [15:0] cmd, input logic zs, input logic [15:0] flip);
    for (int i = 0; i < 6; i++) i_host_spi_model.tx[i] = 24'h0;
    i_host_spi_model.tx[0] = {cmd, 8'h00};
    i_host_spi_model.tx[nw-1] = {crc(nw - 1, i_host_spi_model.tx, zs) ^ flip, 8'h00};
    ex[nw-1] = {crc(nw - 1, ex, 1'b0), 8'h00};
    i_host_spi_model.xfer(nw);
    for (int i = 0; i < nw; i++) chk({8'h0, i_host_spi_model.rx[i]}, {8'h0, ex[i]});
  endtask : fr
  initial begin
    #500000;
    errors++;
    test_done();
  end
  initial begin
    rq = '0;
    load = 1'b0;
    conv = {26'h3ffffff, 26'h0123456, 26'h3000000, 26'h1000000};
    wl = 2'b00;
    ham = 2'b00;
    nrst_i = 1'b0;
    errors = 0;
    compares = 0;
    ex = '{24'ha5c300, 24'h7fffff, 24'h800000, 24'h123456, 24'hffffff, 24'h0};
    repeat (12) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h08, 32'h4, 2'h0);
    wl <= 2'b01;
    rd(8'h3c, 32'h0, 2'h2);
    rd(8'h08, 32'h4, 2'h0);
    wr(8'h10, 32'ha5c3);
    wr(8'h04, 32'hf);
    wr(8'h00, 32'h7);
    @(posedge core_clk_i);
    load <= 1'b1;
    @(posedge core_clk_i);
    load <= 1'b0;
    fr(6, 16'h1234, 1'b0, 16'h0);
    rd(8'h14, 32'h1234, 2'h0);
    fr(6, 16'h4321, 1'b0, 16'h0001);
    rd(8'h08, 32'h5, 2'h0);
    rd(8'h14, 32'h1234, 2'h0);
    rd(8'h0c, 32'h1, 2'h0);
    rd(8'h0c, 32'h0, 2'h0);
    wr(8'h08, 32'h1);
    fr(6, 16'h6000, 1'b0, 16'h0100);
    rd(8'h0c, 32'h1, 2'h0);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h3);
    fr(4, 16'h1111, 1'b1, 16'h0);
    rd(8'h14, 32'h1111, 2'h0);
    test_done();
  end
endmodule : adc_frame_integrity_tb_top
